// *** design/pwmdb_stage.sv ***
// pwmdb_stage: comparator b, two action units and the dead-band unit
// assumes the counter, compare a and mode bits come from the generator
// on hclk; registers reached as an ahb-lite slave, always okay.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/100ps

module pwmdb_stage #(
    parameter int CMP_WIDTH  = 16,
    parameter int TICK_WIDTH = 12
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire pwmdb_pkg::pwmdb_cnt_t  cnt,
    output logic                        cmp_b_pulse,
    output logic                        gen_out_a,
    output logic                        gen_out_b,
    output logic                        final_out_0,
    output logic                        final_out_1
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic apply_act(input logic cur,
                                       input logic [1:0] act);
        case (pwmdb_pkg::pwmdb_act_t'(act))
            pwmdb_pkg::PWMDB_ACT_TOGGLE: apply_act = ~cur;
            pwmdb_pkg::PWMDB_ACT_LOW:    apply_act = 1'b0;
            pwmdb_pkg::PWMDB_ACT_HIGH:   apply_act = 1'b1;
            default:                     apply_act = cur;
        endcase
    endfunction

    function automatic logic [1:0] pick_act(input logic [11:0] acts,
                                            input pwmdb_pkg::pwmdb_ev_t ev,
                                            input logic a_first);
        logic [1:0] a_act;
        logic [1:0] b_act;
        a_act = ev.a_up ? acts[pwmdb_pkg::ACT_AU_LSB +: 2] :
                ev.a_down ? acts[pwmdb_pkg::ACT_AD_LSB +: 2] : 2'h0;
        b_act = ev.b_up ? acts[pwmdb_pkg::ACT_BU_LSB +: 2] :
                ev.b_down ? acts[pwmdb_pkg::ACT_BD_LSB +: 2] : 2'h0;
        if (ev.zero) begin
            pick_act = acts[pwmdb_pkg::ACT_ZERO_LSB +: 2];
        end else if (ev.load) begin
            pick_act = acts[pwmdb_pkg::ACT_LOAD_LSB +: 2];
        end else if ((ev.a_up | ev.a_down) & (ev.b_up | ev.b_down)) begin
            pick_act = a_first ? a_act : b_act;
        end else begin
            pick_act = a_act | b_act;
        end
    endfunction

    function automatic logic [31:0] reg_mask(input logic [11:0] a);
        if (a == pwmdb_pkg::CMP_B_OFF) begin
            reg_mask = 32'h0000FFFF;
        end else if (a == pwmdb_pkg::GEN_A_OFF || a == pwmdb_pkg::GEN_B_OFF
                     || a == pwmdb_pkg::RISE_OFF
                     || a == pwmdb_pkg::FALL_OFF) begin
            reg_mask = 32'h00000FFF;
        end else if (a == pwmdb_pkg::DB_CTL_OFF) begin
            reg_mask = 32'h00000001;
        end else begin
            reg_mask = 32'h00000000;
        end
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [CMP_WIDTH-1:0]  cmp_pend_reg;
    logic [CMP_WIDTH-1:0]  cmp_act_reg;
    logic                  cmp_pend_flag_reg;
    logic                  sync_armed_reg;
    logic [11:0]           act_a_reg;
    logic [11:0]           act_b_reg;
    logic                  db_en_reg;
    logic [TICK_WIDTH-1:0] rise_ticks;
    logic [TICK_WIDTH-1:0] fall_ticks;
    logic [TICK_WIDTH-1:0] rise_cnt_reg;
    logic [TICK_WIDTH-1:0] fall_cnt_reg;
    logic [11:0]           dph_addr_reg;
    logic                  dph_wr_reg;

    // ---------------------------------------------------------------
    // ahb-lite decode
    // ---------------------------------------------------------------
    wire        aph_valid = hsel & htrans[1] & hready;
    wire [11:0] aph_addr  = haddr[pwmdb_pkg::ADDR_BITS-1:0];
    wire        wr_cmp    = dph_wr_reg &&
                            dph_addr_reg == pwmdb_pkg::CMP_B_OFF;
    wire        wr_gen_a  = dph_wr_reg &&
                            dph_addr_reg == pwmdb_pkg::GEN_A_OFF;
    wire        wr_gen_b  = dph_wr_reg &&
                            dph_addr_reg == pwmdb_pkg::GEN_B_OFF;
    wire        wr_db     = dph_wr_reg &&
                            dph_addr_reg == pwmdb_pkg::DB_CTL_OFF;
    wire        wr_rise   = dph_wr_reg &&
                            dph_addr_reg == pwmdb_pkg::RISE_OFF;
    wire        wr_fall   = dph_wr_reg &&
                            dph_addr_reg == pwmdb_pkg::FALL_OFF;
    wire        fwd_hit   = dph_wr_reg && dph_addr_reg == aph_addr;

    logic [31:0] rd_word;
    always_comb begin
        if (aph_addr == pwmdb_pkg::CMP_B_OFF) begin
            rd_word = {16'h0000, cmp_pend_reg};
        end else if (aph_addr == pwmdb_pkg::GEN_A_OFF) begin
            rd_word = {20'h00000, act_a_reg};
        end else if (aph_addr == pwmdb_pkg::GEN_B_OFF) begin
            rd_word = {20'h00000, act_b_reg};
        end else if (aph_addr == pwmdb_pkg::DB_CTL_OFF) begin
            rd_word = {31'h00000000, db_en_reg};
        end else if (aph_addr == pwmdb_pkg::RISE_OFF) begin
            rd_word = {20'h00000, rise_ticks};
        end else if (aph_addr == pwmdb_pkg::FALL_OFF) begin
            rd_word = {20'h00000, fall_ticks};
        end else begin
            rd_word = 32'h00000000;
        end
    end

    // write in data phase, read of same word one cycle later forwarded
    wire [31:0] rd_next = fwd_hit ? (hwdata & reg_mask(aph_addr)) : rd_word;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_addr_reg <= 12'h000;
            dph_wr_reg   <= 1'b0;
            hrdata       <= 32'h00000000;
            hreadyout    <= 1'b0;
            hresp        <= 1'b0;
        end else begin
            dph_addr_reg <= aph_addr;
            dph_wr_reg   <= aph_valid & hwrite;
            hreadyout    <= 1'b1;
            hresp        <= 1'b0;
            if (aph_valid && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_a_reg  <= pwmdb_pkg::ACT_RST;
            act_b_reg  <= pwmdb_pkg::ACT_RST;
            db_en_reg  <= 1'b0;
            rise_ticks <= TICK_WIDTH'(pwmdb_pkg::TICK_RST);
            fall_ticks <= TICK_WIDTH'(pwmdb_pkg::TICK_RST);
        end else begin
            if (wr_gen_a) act_a_reg <= hwdata[pwmdb_pkg::ACT_W-1:0];
            if (wr_gen_b) act_b_reg <= hwdata[pwmdb_pkg::ACT_W-1:0];
            if (wr_db)    db_en_reg <= hwdata[pwmdb_pkg::DB_EN_BIT];
            if (wr_rise)  rise_ticks <= hwdata[TICK_WIDTH-1:0];
            if (wr_fall)  fall_ticks <= hwdata[TICK_WIDTH-1:0];
        end
    end

    // ---------------------------------------------------------------
    // comparator b with deferred update
    // ---------------------------------------------------------------
    wire cmp_apply = cnt.zero & cmp_pend_flag_reg &
                     (~cnt.cmp_b_update_sel | sync_armed_reg);
    wire cmp_in_range = cmp_act_reg <= cnt.load_value;
    wire cmp_b_match = cnt.value == cmp_act_reg && cmp_in_range;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_pend_reg      <= CMP_WIDTH'(pwmdb_pkg::CMP_RST);
            cmp_act_reg       <= CMP_WIDTH'(pwmdb_pkg::CMP_RST);
            cmp_pend_flag_reg <= 1'b0;
            sync_armed_reg    <= 1'b0;
            cmp_b_pulse       <= 1'b0;
        end else begin
            cmp_b_pulse <= cmp_b_match;
            if (wr_cmp) begin
                cmp_pend_reg      <= hwdata[CMP_WIDTH-1:0];
                cmp_pend_flag_reg <= 1'b1;
            end else if (cmp_apply) begin
                cmp_pend_flag_reg <= 1'b0;
            end
            if (cmp_apply) begin
                cmp_act_reg <= cmp_pend_reg;
            end
            // request arriving with the apply is kept for the next value
            if (cnt.sync_update) begin
                sync_armed_reg <= 1'b1;
            end else if (cmp_apply) begin
                sync_armed_reg <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // action units
    // ---------------------------------------------------------------
    wire going_up = cnt.updown_mode & cnt.count_up;
    pwmdb_pkg::pwmdb_ev_t ev;
    assign ev.zero   = cnt.zero;
    assign ev.load   = cnt.load;
    assign ev.a_up   = cnt.cmp_a_match & going_up;
    assign ev.a_down = cnt.cmp_a_match & ~going_up;
    assign ev.b_up   = cmp_b_match & going_up;
    assign ev.b_down = cmp_b_match & ~going_up;

    wire [1:0] sel_a = pick_act(act_a_reg, ev, 1'b1);
    wire [1:0] sel_b = pick_act(act_b_reg, ev, 1'b0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_out_a <= 1'b0;
            gen_out_b <= 1'b0;
        end else begin
            gen_out_a <= apply_act(gen_out_a, sel_a);
            gen_out_b <= apply_act(gen_out_b, sel_b);
        end
    end

    // ---------------------------------------------------------------
    // dead-band unit
    // ---------------------------------------------------------------
    wire rise_done = rise_cnt_reg >= rise_ticks;
    wire fall_done = fall_cnt_reg >= fall_ticks;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            final_out_0  <= 1'b0;
            final_out_1  <= 1'b0;
            rise_cnt_reg <= '0;
            fall_cnt_reg <= '0;
        end else if (!db_en_reg) begin
            final_out_0  <= gen_out_a;
            final_out_1  <= gen_out_b;
            rise_cnt_reg <= '0;
            fall_cnt_reg <= '0;
        end else begin
            if (!gen_out_a) begin
                final_out_0  <= 1'b0;
                rise_cnt_reg <= '0;
            end else if (!final_out_0) begin
                if (rise_done) final_out_0 <= 1'b1;
                else rise_cnt_reg <= rise_cnt_reg + 1'b1;
            end
            if (gen_out_a) begin
                final_out_1  <= 1'b0;
                fall_cnt_reg <= '0;
            end else if (!final_out_1) begin
                if (fall_done) final_out_1 <= 1'b1;
                else fall_cnt_reg <= fall_cnt_reg + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    wire no_ev = ~(ev.zero | ev.load | ev.a_up | ev.a_down |
                   ev.b_up | ev.b_down);
    property p_cmpb_pulse;
        @(posedge hclk) disable iff (!hresetn)
        (cnt.value == cmp_act_reg && cmp_act_reg <= cnt.load_value)
            |=> cmp_b_pulse;
    endproperty
    a_cmpb_pulse: assert property (p_cmpb_pulse)
        else $error("compare b pulse missing");
    property p_cmpb_range;
        @(posedge hclk) disable iff (!hresetn)
        (cmp_act_reg > cnt.load_value) |=> !cmp_b_pulse;
    endproperty
    a_cmpb_range: assert property (p_cmpb_range)
        else $error("compare b pulse beyond load");
    property p_cmpb_update;
        @(posedge hclk) disable iff (!hresetn)
        (cnt.zero && cmp_pend_flag_reg && !cnt.cmp_b_update_sel && !wr_cmp)
            |=> cmp_act_reg == $past(cmp_pend_reg) && !cmp_pend_flag_reg;
    endproperty
    a_cmpb_update: assert property (p_cmpb_update)
        else $error("compare b not applied at zero");
    property p_cmpb_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!cnt.zero) |=> $stable(cmp_act_reg);
    endproperty
    a_cmpb_hold: assert property (p_cmpb_hold)
        else $error("compare b changed off zero");
    property p_cmpb_latest;
        @(posedge hclk) disable iff (!hresetn)
        wr_cmp |=> cmp_pend_reg == $past(hwdata[CMP_WIDTH-1:0]);
    endproperty
    a_cmpb_latest: assert property (p_cmpb_latest)
        else $error("pending compare b not latest");
    property p_quiet;
        @(posedge hclk) disable iff (!hresetn)
        no_ev |=> $stable(gen_out_a) && $stable(gen_out_b);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("generator output moved without event");
    property p_zero_wins;
        @(posedge hclk) disable iff (!hresetn)
        (ev.zero && act_a_reg[1:0] == 2'h3) |=> gen_out_a;
    endproperty
    a_zero_wins: assert property (p_zero_wins)
        else $error("zero action lost");
    property p_a_first;
        @(posedge hclk) disable iff (!hresetn)
        (!ev.zero && !ev.load && ev.a_down && ev.b_down &&
         act_a_reg[7:6] == 2'h3) |=> gen_out_a;
    endproperty
    a_a_first: assert property (p_a_first)
        else $error("unit a priority wrong");
    property p_b_first;
        @(posedge hclk) disable iff (!hresetn)
        (!ev.zero && !ev.load && ev.a_down && ev.b_down &&
         act_b_reg[11:10] == 2'h3 && act_b_reg[7:6] == 2'h2) |=> gen_out_b;
    endproperty
    a_b_first: assert property (p_b_first)
        else $error("unit b priority wrong");
    property p_pass;
        @(posedge hclk) disable iff (!hresetn)
        !db_en_reg |=> final_out_0 == $past(gen_out_a) &&
                       final_out_1 == $past(gen_out_b);
    endproperty
    a_pass: assert property (p_pass)
        else $error("pass-through broken");
    property p_db_pair;
        @(posedge hclk) disable iff (!hresetn)
        db_en_reg |=> !(final_out_0 && final_out_1);
    endproperty
    a_db_pair: assert property (p_db_pair)
        else $error("dead-band outputs overlap");
    c_cmpb_apply: cover property (@(posedge hclk) disable iff (!hresetn)
        cmp_apply && cnt.cmp_b_update_sel);
    c_db_rise: cover property (@(posedge hclk) disable iff (!hresetn)
        db_en_reg && rise_ticks > 12'h001 && $rose(final_out_0));
    c_updown: cover property (@(posedge hclk) disable iff (!hresetn)
        ev.b_up && act_a_reg[9:8] != 2'h0);

endmodule // pwmdb_stage

// *** pkg/pwmdb_pkg.sv ***
// pwmdb_pkg: constants and types of the pwm action and dead-band stage
// assumes a 32-bit ahb-lite register bus with word-aligned registers
package pwmdb_pkg;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] CMP_B_OFF   = 12'h05C;
    localparam logic [11:0] GEN_A_OFF   = 12'h060;
    localparam logic [11:0] GEN_B_OFF   = 12'h064;
    localparam logic [11:0] DB_CTL_OFF  = 12'h068;
    localparam logic [11:0] RISE_OFF    = 12'h06C;
    localparam logic [11:0] FALL_OFF    = 12'h070;
    localparam int          ADDR_BITS   = 12;

    // ---------------------------------------------------------------
    // field layout and reset values
    // ---------------------------------------------------------------
    localparam int          CMP_W       = 16;
    localparam int          ACT_W       = 12;
    localparam int          TICK_W      = 12;
    localparam int          DB_EN_BIT   = 0;
    localparam int          ACT_ZERO_LSB = 0;
    localparam int          ACT_LOAD_LSB = 2;
    localparam int          ACT_AU_LSB  = 4;
    localparam int          ACT_AD_LSB  = 6;
    localparam int          ACT_BU_LSB  = 8;
    localparam int          ACT_BD_LSB  = 10;
    localparam logic [15:0] CMP_RST     = 16'h0000;
    localparam logic [11:0] ACT_RST     = 12'h000;
    localparam logic [11:0] TICK_RST    = 12'h000;

    // ---------------------------------------------------------------
    // action encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PWMDB_ACT_NONE   = 2'h0,
        PWMDB_ACT_TOGGLE = 2'h1,
        PWMDB_ACT_LOW    = 2'h2,
        PWMDB_ACT_HIGH   = 2'h3
    } pwmdb_act_t;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        zero;
        logic        load;
        logic        a_up;
        logic        a_down;
        logic        b_up;
        logic        b_down;
    } pwmdb_ev_t;

    typedef struct packed {
        logic [15:0] value;
        logic [15:0] load_value;
        logic        count_up;
        logic        zero;
        logic        load;
        logic        cmp_a_match;
        logic        updown_mode;
        logic        cmp_b_update_sel;
        logic        sync_update;
    } pwmdb_cnt_t;

endpackage

// *** verification/pwm_gen_action_deadband_test.sv ***
// pwm_gen_action_deadband_test: self-checking bench for pwmdb_stage
// assumes the stage is the only slave, hready fed back from hreadyout
`timescale 1ns/100ps

module pwm_gen_action_deadband_test;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic                  hclk        = 1'b0;
    logic                  hresetn     = 1'b0;
    logic                  hsel        = 1'b0;
    logic [31:0]           haddr       = 32'h0;
    logic [1:0]            htrans      = 2'h0;
    logic                  hwrite      = 1'b0;
    logic [31:0]           hwdata      = 32'h0;
    wire logic             hready;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  hresp;
    pwmdb_pkg::pwmdb_cnt_t cnt;
    logic                  cmp_b_pulse;
    logic                  gen_out_a;
    logic                  gen_out_b;
    logic                  final_out_0;
    logic                  final_out_1;
    int                    error_cnt   = 0;
    int                    n_compared  = 0;
    int                    seed        = 13;
    int                    n;
    logic [31:0]           rd;
    logic [31:0]           d;
    logic [1:0]            ca;
    logic [1:0]            cb;
    logic                  ea;
    logic                  eb;
    logic                  zl;
    logic [11:0]           offs [6];
    logic [31:0]           msk  [6];

    assign hready = hreadyout;
    always #20 hclk = ~hclk;

    pwmdb_stage u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cnt(cnt), .cmp_b_pulse(cmp_b_pulse),
        .gen_out_a(gen_out_a), .gen_out_b(gen_out_b),
        .final_out_0(final_out_0), .final_out_1(final_out_1)
    );

    // ---------------------------------------------------------------
    // compare, bus and stimulus tasks
    // ---------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // one-cycle counter events, then look between edges
    task automatic ev(input logic z, input logic l, input logic a,
                      input logic [15:0] v);
        @(posedge hclk);
        cnt.zero        <= z;
        cnt.load        <= l;
        cnt.cmp_a_match <= a;
        cnt.value       <= v;
        @(posedge hclk);
        cnt.zero        <= 1'b0;
        cnt.load        <= 1'b0;
        cnt.cmp_a_match <= 1'b0;
        cnt.value       <= 16'h0FFF;
        @(negedge hclk);
    endtask

    task automatic probe(input logic [15:0] v, input logic e);
        @(posedge hclk) cnt.value <= v;
        @(posedge hclk);
        @(negedge hclk) chk_pin(cmp_b_pulse, e);
    endtask

    // edges from a zero event until the chosen final output is high
    task automatic meas(input logic which);
        @(posedge hclk) cnt.zero <= 1'b1;
        n = 0;
        do begin
            @(posedge hclk) cnt.zero <= 1'b0;
            @(negedge hclk);
            n++;
        end while ((which ? final_out_1 : final_out_0) !== 1'b1 && n < 50);
    endtask

    function automatic logic act(input logic cur, input logic [1:0] c);
        case (c)
            2'h0: return cur;
            2'h1: return ~cur;
            2'h2: return 1'b0;
            default: return 1'b1;
        endcase
    endfunction

    task automatic done_msg(input string s);
        $display("test %s done", s);
    endtask

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        #(10000 * 40);
        error_cnt++;
        test_done();
    end

    initial begin
        cnt = '0;
        cnt.value = 16'h0FFF;
        cnt.load_value = 16'hFFFF;
        offs = '{pwmdb_pkg::CMP_B_OFF, pwmdb_pkg::GEN_A_OFF,
                 pwmdb_pkg::GEN_B_OFF, pwmdb_pkg::DB_CTL_OFF,
                 pwmdb_pkg::RISE_OFF, pwmdb_pkg::FALL_OFF};
        msk = '{32'h0000FFFF, 32'h00000FFF, 32'h00000FFF, 32'h00000001,
                32'h00000FFF, 32'h00000FFF};
        repeat (12) @(posedge hclk);
        chk_pin(hreadyout, 1'b0);
        hresetn <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        @(negedge hclk);
        chk_pin(gen_out_a, 1'b0);
        chk_pin(gen_out_b, 1'b0);
        chk_pin(final_out_0, 1'b0);
        chk_pin(final_out_1, 1'b0);
        chk_pin(cmp_b_pulse, 1'b0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, offs[i], 32'h0);
            chk_reg(rd, 32'h0);
        end
        for (int k = 0; k < 18; k++) begin
            d = $random(seed);
            bus(1'b1, offs[k % 6], d);
            bus(1'b0, offs[k % 6], 32'h0);
            chk_reg(rd, d & msk[k % 6]);
        end
        bus(1'b1, 12'h074, 32'hFFFFFFFF);
        bus(1'b0, 12'h074, 32'h0);
        chk_reg(rd, 32'h0);
        chk_pin(hresp, 1'b0);
        done_msg("registers");
        bus(1'b1, pwmdb_pkg::DB_CTL_OFF, 32'h0);
        bus(1'b1, pwmdb_pkg::CMP_B_OFF, 32'h00000100);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h0000000A);
        bus(1'b1, pwmdb_pkg::GEN_B_OFF, 32'h0000000A);
        ev(1'b1, 1'b0, 1'b0, 16'h0FFF);
        ea = 1'b0;
        eb = 1'b0;
        for (int k = 0; k < 12; k++) begin
            ca = 2'(k);
            cb = 2'($random(seed));
            zl = 1'($random(seed));
            bus(1'b1, pwmdb_pkg::GEN_A_OFF, {28'h0, ca, ca});
            bus(1'b1, pwmdb_pkg::GEN_B_OFF, {28'h0, cb, cb});
            ev(zl, ~zl, 1'b0, 16'h0FFF);
            ea = act(ea, ca);
            eb = act(eb, cb);
            chk_pin(gen_out_a, ea);
            chk_pin(gen_out_b, eb);
            @(negedge hclk);
            chk_pin(final_out_0, ea);
            chk_pin(final_out_1, eb);
        end
        done_msg("actions");
        probe(16'h0100, 1'b1);
        @(posedge hclk) cnt.load_value <= 16'h00FF;
        probe(16'h0100, 1'b0);
        @(posedge hclk) cnt.load_value <= 16'hFFFF;
        @(posedge hclk) cnt.cmp_b_update_sel <= 1'b1;
        bus(1'b1, pwmdb_pkg::CMP_B_OFF, 32'h00000200);
        bus(1'b1, pwmdb_pkg::CMP_B_OFF, 32'h00000300);
        ev(1'b1, 1'b0, 1'b0, 16'h0FFF);
        probe(16'h0100, 1'b1);
        @(posedge hclk) cnt.sync_update <= 1'b1;
        @(posedge hclk) cnt.sync_update <= 1'b0;
        ev(1'b1, 1'b0, 1'b0, 16'h0FFF);
        probe(16'h0200, 1'b0);
        probe(16'h0300, 1'b1);
        done_msg("compare b");
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h000008C2);
        bus(1'b1, pwmdb_pkg::GEN_B_OFF, 32'h00000C82);
        ev(1'b1, 1'b0, 1'b0, 16'h0FFF);
        ev(1'b0, 1'b0, 1'b1, 16'h0300);
        chk_pin(gen_out_a, 1'b1);
        chk_pin(gen_out_b, 1'b1);
        ev(1'b1, 1'b0, 1'b1, 16'h0300);
        chk_pin(gen_out_a, 1'b0);
        chk_pin(gen_out_b, 1'b0);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h00000032);
        @(posedge hclk) cnt.count_up <= 1'b1;
        ev(1'b0, 1'b0, 1'b1, 16'h0FFF);
        chk_pin(gen_out_a, 1'b0);
        @(posedge hclk) cnt.updown_mode <= 1'b1;
        ev(1'b0, 1'b0, 1'b1, 16'h0FFF);
        chk_pin(gen_out_a, 1'b1);
        done_msg("priority");
        bus(1'b1, pwmdb_pkg::RISE_OFF, 32'h3);
        bus(1'b1, pwmdb_pkg::FALL_OFF, 32'h2);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h2);
        ev(1'b1, 1'b0, 1'b0, 16'h0FFF);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h3);
        meas(1'b0);
        chk_reg(32'(n), 32'h2);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h2);
        ev(1'b1, 1'b0, 1'b0, 16'h0FFF);
        bus(1'b1, pwmdb_pkg::DB_CTL_OFF, 32'h1);
        repeat (8) @(posedge hclk);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h3);
        meas(1'b0);
        chk_reg(32'(n), 32'h5);
        chk_pin(final_out_1, 1'b0);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h2);
        meas(1'b1);
        chk_reg(32'(n), 32'h4);
        chk_pin(final_out_0, 1'b0);
        bus(1'b1, pwmdb_pkg::RISE_OFF, 32'h0);
        bus(1'b1, pwmdb_pkg::GEN_A_OFF, 32'h3);
        meas(1'b0);
        chk_reg(32'(n), 32'h2);
        chk_pin(final_out_1, 1'b0);
        done_msg("dead-band");
        test_done();
    end

endmodule // pwm_gen_action_deadband_test
